/* File: pcr_array_model.sv */
// behavioural memory array behind the block's request port
`timescale 1ns/1ps
module pcr_array_model (
	input wire logic clk,
	input wire logic arrayRead,
	input wire logic arrayWrite,
	input wire logic [20:0] arrayAddr,
	input wire logic [15:0] arrayWdata,
	input wire logic [1:0] arrayByteEn,
	output logic [15:0] arrayRdata,
	output logic [7:0] writeCount
);
	logic [15:0] mem [int];
	logic [15:0] old;
	initial begin
		arrayRdata = 16'h0;
		writeCount = 8'h0;
	end
	always @(posedge clk) begin
		old = mem.exists(arrayAddr) ? mem[arrayAddr] : ~arrayAddr[15:0];
		if (arrayWrite) begin
			mem[arrayAddr] = {arrayByteEn[1] ? arrayWdata[15:8] : old[15:8],
				arrayByteEn[0] ? arrayWdata[7:0] : old[7:0]};
			writeCount <= writeCount + 8'h1;
		end
		// outside a read the data keeps toggling so stale values never look valid
		arrayRdata <= arrayRead ? old : ~arrayRdata;
	end
endmodule // pcr_array_model

/* File: pcr_asserts.sv */
// port-level checks for the configuration register access block
`timescale 1ns/1ps
module pcr_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic configSelect,
	input wire logic writeEnableN,
	input wire logic outputEnableN,
	input wire logic dqOe,
	input wire logic arrayRead,
	input wire logic arrayWrite,
	input wire logic [20:0] arrayAddr,
	input wire logic [15:0] busConfig,
	input wire logic [15:0] refreshConfig
);
	logic [4:0] weAge;
	logic [20:0] prevAddr;
	logic prevPulse;
	wire pulse = arrayRead | arrayWrite;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// age of the last write strobe, so a register change can be tied to a write
	always @(posedge clk) begin
		prevAddr <= arrayAddr;
		prevPulse <= rst_n & pulse;
		if (!rst_n)
			weAge <= 5'h1F;
		else if (!writeEnableN)
			weAge <= 5'h0;
		else if (weAge != 5'h1F)
			weAge <= weAge + 5'h1;
	end
	a_reset_bus: assert property ($rose(rst_n) |-> busConfig == 16'h9D1F)
		else $error("bus config not at power-up value");
	a_reset_refresh: assert property ($rose(rst_n) |-> refreshConfig == 16'h0010)
		else $error("refresh config not at power-up value");
	a_reset_quiet: assert property ($rose(rst_n) |-> !dqOe && !pulse)
		else $error("activity right after reset");
	a_bus_cause: assert property ($changed(busConfig) |-> weAge < 5'd12)
		else $error("bus config changed without a write");
	a_ref_cause: assert property ($changed(refreshConfig) |-> weAge < 5'd12)
		else $error("refresh config changed without a write");
	a_cfg_no_array: assert property (configSelect [*6] |-> !pulse)
		else $error("array touched during register access");
	a_oe_idle: assert property (outputEnableN [*8] |-> !dqOe)
		else $error("data driven without output enable");
	a_wrap_order: assert property (!busConfig[3] && busConfig[2:0] == 3'h1 && pulse
		&& prevPulse |-> arrayAddr[1:0] == prevAddr[1:0] + 2'h1
		&& arrayAddr[20:2] == prevAddr[20:2])
		else $error("wrapped burst order wrong");
	a_linear_step: assert property (busConfig[3] && pulse && prevPulse
		|-> arrayAddr == prevAddr + 21'h1)
		else $error("linear burst skipped an address");
	a_row_wait: assert property (busConfig[3] && pulse && prevPulse
		|-> arrayAddr[6:0] != 7'h0)
		else $error("row crossed without a wait");
endmodule // pcr_asserts

/* File: pcr_burst_addr.v */
// burst word address sequencer with wrap and row-crossing wait
`timescale 1ns/1ps
`include "pcr_consts.vh"
module pcr_burst_addr #(
	parameter ADDR_W = 21,
	parameter ROW_OPEN_CYCLES = `PCR_ROW_OPEN_CYCLES
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire [ADDR_W-1:0] startAddr,
	input wire advance,
	input wire [2:0] lengthCode,
	input wire linearMode,
	output reg [ADDR_W-1:0] wordAddr,
	output reg rowWait
);
	reg [4:0] lenMask;
	reg wrapOn;
	reg [3:0] waitCount;
	wire [ADDR_W-1:0] linearNext;
	wire [4:0] wrapLow;

	// mask of the aligned block; zero means continuous
	function [4:0] maskOf;
		input [2:0] code;
		begin
			case (code)
				`PCR_LEN_4: maskOf = 5'h03;
				`PCR_LEN_8: maskOf = 5'h07;
				`PCR_LEN_16: maskOf = 5'h0F;
				`PCR_LEN_32: maskOf = 5'h1F;
				default: maskOf = 5'h00;
			endcase
		end
	endfunction

	assign linearNext = wordAddr + {{(ADDR_W-1){1'b0}}, 1'b1};
	assign wrapLow = ((wordAddr[4:0] + 5'h01) & lenMask) | (wordAddr[4:0] & ~lenMask);

	// one sequencer serves read and write bursts alike
	always @(posedge clk) begin
		if (!rst_n) begin
			wordAddr <= {ADDR_W{1'b0}};
			rowWait <= 1'b0;
			lenMask <= 5'h00;
			wrapOn <= 1'b0;
			waitCount <= 4'h0;
		end else if (start) begin
			wordAddr <= startAddr;
			lenMask <= maskOf(lengthCode);
			wrapOn <= ~linearMode && (maskOf(lengthCode) != 5'h00);
			rowWait <= 1'b0;
			waitCount <= 4'h0;
		end else if (rowWait) begin
			// next row is being opened; release after the open time
			if (waitCount == ROW_OPEN_CYCLES[3:0] - 4'h1) begin
				rowWait <= 1'b0;
				waitCount <= 4'h0;
			end else begin
				waitCount <= waitCount + 4'h1;
			end
		end else if (advance) begin
			if (wrapOn) begin
				wordAddr <= {wordAddr[ADDR_W-1:5], wrapLow};
			end else begin
				wordAddr <= linearNext;
				if (&wordAddr[`PCR_ROW_BITS-1:0])
					rowWait <= 1'b1;
			end
		end
	end
endmodule // pcr_burst_addr

/* File: pcr_consts.vh */
// constants for the pseudo-static ram configuration register access block
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

`define PCR_CLK_PERIOD_NS 10
`define PCR_ROW_OPEN_NS 20
`define PCR_ROW_OPEN_CYCLES ((`PCR_ROW_OPEN_NS + `PCR_CLK_PERIOD_NS - 1) / `PCR_CLK_PERIOD_NS)

`define PCR_BUS_CONFIG_RESET 16'h9D1F
`define PCR_REFRESH_CONFIG_RESET 16'h0010
`define PCR_TOP_ADDR 21'h1FFFFF

`define PCR_REG_SEL_MSB 19
`define PCR_REG_SEL_LSB 18
`define PCR_SEL_REFRESH 2'h0
`define PCR_SEL_ID 2'h1
`define PCR_SEL_BUS 2'h2

`define PCR_SW_DATA_REFRESH 16'h0000
`define PCR_SW_DATA_BUS 16'h0001
`define PCR_SW_DATA_ID 16'h0002

`define PCR_BUS_LEN_MSB 2
`define PCR_BUS_LEN_LSB 0
`define PCR_BUS_WRAP_BIT 3
`define PCR_BUS_WAIT_POL_BIT 10
`define PCR_BUS_OPMODE_BIT 15

`define PCR_LEN_4 3'h1
`define PCR_LEN_8 3'h2
`define PCR_LEN_16 3'h3
`define PCR_LEN_32 3'h4
`define PCR_ROW_BITS 7

`endif

/* File: pcr_pin_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pcr_pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] pinIn,
	output reg [WIDTH-1:0] pinOut
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	// stage1 feeds stage2 only; a bit moves once stage2 and stage3 agree
	always @(posedge clk) begin
		if (!rst_n) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			pinOut <= INIT;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			pinOut <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & pinOut);
		end
	end
endmodule // pcr_pin_sync

/* File: pcr_register_access.v */
// configuration register access and array request front end
`timescale 1ns/1ps
`include "pcr_consts.vh"
module pcr_register_access #(
	parameter ADDR_W = 21,
	parameter DATA_W = 16,
	parameter [15:0] DEVICE_ID = 16'h0A5A // arbitrary identification value
) (
	input wire clk,
	input wire rst_n,
	input wire configSelect,
	input wire addressValidN,
	input wire chipEnableN,
	input wire writeEnableN,
	input wire outputEnableN,
	input wire lowerByteEnableN,
	input wire upperByteEnableN,
	input wire [ADDR_W-1:0] addrPin,
	input wire [DATA_W-1:0] dqIn,
	output reg [DATA_W-1:0] dqOut,
	output reg dqOe,
	output reg waitOut,
	output reg arrayRead,
	output reg arrayWrite,
	output reg [ADDR_W-1:0] arrayAddr,
	output reg [DATA_W-1:0] arrayWdata,
	output reg [1:0] arrayByteEn,
	input wire [DATA_W-1:0] arrayRdata,
	output reg [15:0] busConfig,
	output reg [15:0] refreshConfig
);
	localparam SEQ_IDLE = 2'h0;
	localparam SEQ_READ1 = 2'h1;
	localparam SEQ_READ2 = 2'h2;
	localparam SEQ_PICKED = 2'h3;
	localparam SYNC_W = 7 + ADDR_W + DATA_W;
	localparam [SYNC_W-1:0] SYNC_INIT = {7'b0111111, {(ADDR_W + DATA_W){1'b0}}};

	wire [SYNC_W-1:0] syncOut;
	wire sCre;
	wire sAdvN;
	wire sCeN;
	wire sWeN;
	wire sOeN;
	wire sLbN;
	wire sUbN;
	wire [ADDR_W-1:0] sAddr;
	wire [DATA_W-1:0] sDq;

	reg prevCeN;
	reg prevAdvN;
	reg prevWeN;
	reg opOpen;
	reg opWrite;
	reg wrDone;
	reg latchCre;
	reg latchTop;
	reg [ADDR_W-1:0] latchAddr;
	reg [1:0] swState;
	reg [1:0] swSel;
	reg swSelValid;
	reg burstActive;
	reg burstWrite;
	reg rdTake;

	wire [ADDR_W-1:0] burstAddr;
	wire rowWait;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function isTop;
		input [ADDR_W-1:0] a;
		begin
			isTop = (a == `PCR_TOP_ADDR);
		end
	endfunction

	function [15:0] regValue;
		input [1:0] sel;
		input [15:0] busVal;
		input [15:0] refVal;
		begin
			case (sel)
				`PCR_SEL_BUS: regValue = busVal;
				`PCR_SEL_REFRESH: regValue = refVal;
				`PCR_SEL_ID: regValue = DEVICE_ID;
				default: regValue = 16'h0000;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin capture

	pcr_pin_sync #(
		.WIDTH(SYNC_W),
		.INIT(SYNC_INIT)
	) pinSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn({configSelect, addressValidN, chipEnableN, writeEnableN, outputEnableN,
			lowerByteEnableN, upperByteEnableN, addrPin, dqIn}),
		.pinOut(syncOut)
	);

	assign sCre = syncOut[SYNC_W-1];
	assign sAdvN = syncOut[SYNC_W-2];
	assign sCeN = syncOut[SYNC_W-3];
	assign sWeN = syncOut[SYNC_W-4];
	assign sOeN = syncOut[SYNC_W-5];
	assign sLbN = syncOut[SYNC_W-6];
	assign sUbN = syncOut[SYNC_W-7];
	assign sAddr = syncOut[ADDR_W+DATA_W-1:DATA_W];
	assign sDq = syncOut[DATA_W-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// operation framing

	wire ceRise = sCeN & ~prevCeN;
	wire advRise = sAdvN & ~prevAdvN;
	wire weRise = sWeN & ~prevWeN;
	wire newOp = ~sCeN & ~sAdvN & (prevAdvN | prevCeN);
	wire opEnd = opOpen & (ceRise | newOp);
	// first of the three rising edges closes a write; byte enables play no part
	wire wrCommit = opOpen & opWrite & ~wrDone & (ceRise | weRise | advRise);
	wire syncMode = ~busConfig[`PCR_BUS_OPMODE_BIT];
	wire burstPath = syncMode & ~sCre;
	wire seqTop = latchTop & ~latchCre;
	wire seqHold = wrCommit & seqTop & ((swState == SEQ_READ2) | (swState == SEQ_PICKED));
	wire creLoad = wrCommit & latchCre;
	wire seqLoad = wrCommit & seqTop & (swState == SEQ_PICKED) & swSelValid;
	wire asyncWr = wrCommit & ~latchCre & ~seqHold & ~burstActive;
	wire regDrive = latchCre | (seqTop & (swState == SEQ_PICKED));
	wire [1:0] readSel = latchCre ? latchAddr[`PCR_REG_SEL_MSB:`PCR_REG_SEL_LSB] : swSel;
	// a new address while valid is still low starts another array read
	wire rdIssue = ~burstPath & ~sCre & sWeN & ~sCeN & ~sAdvN &
		(newOp | (opOpen & (sAddr != latchAddr)));
	wire burstStep = burstActive & ~sCeN & ~rowWait & ~newOp;

	always @(posedge clk) begin
		if (!rst_n) begin
			prevCeN <= 1'b1;
			prevAdvN <= 1'b1;
			prevWeN <= 1'b1;
		end else begin
			prevCeN <= sCeN;
			prevAdvN <= sAdvN;
			prevWeN <= sWeN;
		end
	end

	// address follows the pins while valid is low and holds once it rises
	always @(posedge clk) begin
		if (!rst_n) begin
			latchAddr <= {ADDR_W{1'b0}};
			latchCre <= 1'b0;
			latchTop <= 1'b0;
		end else if (~sCeN & ~sAdvN) begin
			latchAddr <= sAddr;
			latchCre <= sCre;
			latchTop <= isTop(sAddr);
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			opOpen <= 1'b0;
			opWrite <= 1'b0;
			wrDone <= 1'b0;
		end else begin
			if (newOp)
				opOpen <= 1'b1;
			else if (ceRise)
				opOpen <= 1'b0;
			if (newOp)
				opWrite <= ~sWeN;
			else if (opOpen & ~sWeN)
				opWrite <= 1'b1;
			if (newOp)
				wrDone <= 1'b0;
			else if (wrCommit)
				wrDone <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software access sequence

	// any access that is not the next expected one restarts the count, except a further top read after two reads, which keeps it at two
	always @(posedge clk) begin
		if (!rst_n) begin
			swState <= SEQ_IDLE;
		end else if (opEnd) begin
			case (swState)
				SEQ_IDLE: swState <= (seqTop & ~opWrite) ? SEQ_READ1 : SEQ_IDLE;
				SEQ_READ1: swState <= (seqTop & ~opWrite) ? SEQ_READ2 : SEQ_IDLE;
				SEQ_READ2: begin
					if (seqTop & opWrite)
						swState <= SEQ_PICKED;
					else
						swState <= (seqTop & ~opWrite) ? SEQ_READ2 : SEQ_IDLE;
				end
				SEQ_PICKED: swState <= SEQ_IDLE;
				default: swState <= SEQ_IDLE;
			endcase
		end
	end

	// the third access, a write, names the register; unknown data blocks the final write, while a final read returns the refresh register
	always @(posedge clk) begin
		if (!rst_n) begin
			swSel <= `PCR_SEL_REFRESH;
			swSelValid <= 1'b0;
		end else if (wrCommit & seqTop & (swState == SEQ_READ2)) begin
			case (sDq)
				`PCR_SW_DATA_REFRESH: begin
					swSel <= `PCR_SEL_REFRESH;
					swSelValid <= 1'b1;
				end
				`PCR_SW_DATA_BUS: begin
					swSel <= `PCR_SEL_BUS;
					swSelValid <= 1'b1;
				end
				`PCR_SW_DATA_ID: begin
					swSel <= `PCR_SEL_ID;
					swSelValid <= 1'b1;
				end
				default: begin
					swSel <= `PCR_SEL_REFRESH;
					swSelValid <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	// written values steer the very next operation, never the one in flight
	always @(posedge clk) begin
		if (!rst_n) begin
			busConfig <= `PCR_BUS_CONFIG_RESET;
			refreshConfig <= `PCR_REFRESH_CONFIG_RESET;
		end else if (creLoad) begin
			case (latchAddr[`PCR_REG_SEL_MSB:`PCR_REG_SEL_LSB])
				`PCR_SEL_BUS: busConfig <= latchAddr[15:0];
				`PCR_SEL_REFRESH: refreshConfig <= latchAddr[15:0];
				default: busConfig <= busConfig;
			endcase
		end else if (seqLoad) begin
			case (swSel)
				`PCR_SEL_BUS: busConfig <= sDq;
				`PCR_SEL_REFRESH: refreshConfig <= sDq;
				default: busConfig <= busConfig;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// synchronous burst

	// initial latency is not modelled here; words step from the cycle after start
	pcr_burst_addr #(
		.ADDR_W(ADDR_W),
		.ROW_OPEN_CYCLES(`PCR_ROW_OPEN_CYCLES)
	) burstSeq (
		.clk(clk),
		.rst_n(rst_n),
		.start(newOp & burstPath),
		.startAddr(sAddr),
		.advance(burstStep),
		.lengthCode(busConfig[`PCR_BUS_LEN_MSB:`PCR_BUS_LEN_LSB]),
		.linearMode(busConfig[`PCR_BUS_WRAP_BIT]),
		.wordAddr(burstAddr),
		.rowWait(rowWait)
	);

	// a rising enable ends the burst; the sequencer is then simply no longer advanced
	always @(posedge clk) begin
		if (!rst_n) begin
			burstActive <= 1'b0;
			burstWrite <= 1'b0;
		end else if (newOp) begin
			burstActive <= burstPath;
			burstWrite <= ~sWeN;
		end else if (ceRise) begin
			burstActive <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// array requests and bus outputs

	always @(posedge clk) begin
		if (!rst_n) begin
			arrayRead <= 1'b0;
			arrayWrite <= 1'b0;
			arrayAddr <= {ADDR_W{1'b0}};
			arrayWdata <= {DATA_W{1'b0}};
			arrayByteEn <= 2'h0;
		end else begin
			arrayRead <= rdIssue | (burstStep & ~burstWrite);
			// register loads and, in asynchronous mode, the hidden top-address writes never reach the array
			arrayWrite <= asyncWr | (burstStep & burstWrite);
			// burst addresses win over the pin address while a burst runs
			if (burstStep)
				arrayAddr <= burstAddr;
			else if (rdIssue)
				arrayAddr <= sAddr;
			else
				arrayAddr <= latchAddr;
			arrayWdata <= sDq;
			arrayByteEn <= ~{sUbN, sLbN};
		end
	end

	// configuration register reads look only at bits 19:18 of the address; software sequence reads use the picked register
	always @(posedge clk) begin
		if (!rst_n) begin
			dqOut <= {DATA_W{1'b0}};
			dqOe <= 1'b0;
			rdTake <= 1'b0;
		end else begin
			// array data is valid only the cycle after a request; catch it then and hold it
			rdTake <= arrayRead;
			if (regDrive)
				dqOut <= regValue(readSel, busConfig, refreshConfig);
			else if (rdTake)
				dqOut <= arrayRdata;
			dqOe <= opOpen & ~sCeN & ~sOeN & sWeN & (regDrive | ~(sLbN & sUbN));
		end
	end

	// wait drives the configured polarity; reset value is the idle level
	always @(posedge clk) begin
		if (!rst_n)
			waitOut <= 1'b0;
		else if (busConfig[`PCR_BUS_WAIT_POL_BIT])
			waitOut <= burstActive & rowWait;
		else
			waitOut <= ~(burstActive & rowWait);
	end
endmodule // pcr_register_access

/* File: tb_psram_config_register_access.sv */
// self-checking bench for the configuration register access block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb_psram_config_register_access;
	localparam logic [15:0] ID = 16'h0C3C; // arbitrary value
	localparam logic [20:0] TOP = 21'h1FFFFF;
	logic clk, rst_n, configSelect, addressValidN, chipEnableN, writeEnableN;
	logic outputEnableN, lowerByteEnableN, upperByteEnableN, dqOe, waitOut;
	logic arrayRead, arrayWrite, sawWait, qOe;
	logic [20:0] addrPin, arrayAddr;
	logic [15:0] dqIn, dqOut, arrayWdata, arrayRdata, busConfig, refreshConfig, q;
	logic [1:0] arrayByteEn;
	logic [7:0] writeCount;
	logic [33:0] rows [0:2];
	logic [20:0] seen [$];
	int i, j, cycles, bad_count, checks_done;
	pcr_register_access #(.DEVICE_ID(ID)) dut_u (.clk(clk), .rst_n(rst_n),
		.configSelect(configSelect), .addressValidN(addressValidN),
		.chipEnableN(chipEnableN), .writeEnableN(writeEnableN),
		.outputEnableN(outputEnableN), .lowerByteEnableN(lowerByteEnableN),
		.upperByteEnableN(upperByteEnableN), .addrPin(addrPin), .dqIn(dqIn),
		.dqOut(dqOut), .dqOe(dqOe), .waitOut(waitOut), .arrayRead(arrayRead),
		.arrayWrite(arrayWrite), .arrayAddr(arrayAddr), .arrayWdata(arrayWdata),
		.arrayByteEn(arrayByteEn), .arrayRdata(arrayRdata), .busConfig(busConfig),
		.refreshConfig(refreshConfig));
	pcr_array_model arr_u (.clk(clk), .arrayRead(arrayRead), .arrayWrite(arrayWrite),
		.arrayAddr(arrayAddr), .arrayWdata(arrayWdata), .arrayByteEn(arrayByteEn),
		.arrayRdata(arrayRdata), .writeCount(writeCount));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (arrayRead || arrayWrite)
			seen.push_back(arrayAddr);
		if (waitOut)
			sawWait = 1'b1;
		if (cycles == 3000) begin
			bad_count++;
			test_done;
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task rst;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask
	// pins stay put for hold cycles so the three-flop synchronisers see them
	task op(input logic cs, input logic [20:0] a, input logic [15:0] d, input logic wr,
		input int hold);
		@(posedge clk);
		configSelect <= cs;
		addrPin <= a;
		dqIn <= d;
		lowerByteEnableN <= cs;
		upperByteEnableN <= cs;
		{chipEnableN, addressValidN} <= 2'h0;
		writeEnableN <= !wr;
		outputEnableN <= wr;
		repeat (hold) @(posedge clk);
		q = dqOut;
		qOe = dqOe;
		{chipEnableN, addressValidN, writeEnableN, outputEnableN} <= 4'hF;
		repeat (6) @(posedge clk);
	endtask
	task sw(input logic [15:0] sel, input logic [15:0] v, input logic rd);
		op(1'b0, TOP, 16'h0, 1'b0, 8);
		op(1'b0, TOP, 16'h0, 1'b0, 8);
		op(1'b0, TOP, sel, 1'b1, 8);
		op(1'b0, TOP, v, !rd, 8);
	endtask
	//////////////////////////////
	initial begin
		clk = 1'b0;
		{configSelect, addrPin, dqIn, lowerByteEnableN, upperByteEnableN} <= '0;
		{addressValidN, chipEnableN, writeEnableN, outputEnableN} <= 4'hF;
		rows[0] = {2'h2, 16'h951A, 16'h951A};
		rows[1] = {2'h0, 16'h0013, 16'h0013};
		rows[2] = {2'h1, 16'hFFFF, ID};
		rst;
		`CHK(busConfig, 16'h9D1F)
		`CHK(refreshConfig, 16'h0010)
		for (i = 0; i < 3; i++) begin
			op(1'b1, {1'b0, rows[i][33:32], 2'h0, rows[i][31:16]}, 16'hFFFF, 1'b1, 8);
			op(1'b1, {1'b1, rows[i][33:32], 18'h3FFFF}, 16'h0, 1'b0, 8);
			`CHK(q, rows[i][15:0])
			`CHK(qOe, 1'b1)
		end
		op(1'b0, 21'd5, 16'h1234, 1'b1, 8);
		op(1'b0, 21'd5, 16'h0, 1'b0, 9);
		`CHK(q, 16'h1234)
		`CHK(qOe, 1'b1)
		sw(16'h0000, 16'h0031, 1'b0);
		`CHK(refreshConfig, 16'h0031)
		sw(16'h0001, 16'h9D0F, 1'b0);
		`CHK(busConfig, 16'h9D0F)
		sw(16'h0002, 16'h0, 1'b1);
		`CHK(q, ID)
		op(1'b1, {1'b1, 2'h2, 18'h0}, 16'h0, 1'b0, 8);
		`CHK(q, 16'h9D0F)
		`CHK(writeCount, 8'h01)
		op(1'b0, TOP, 16'h0, 1'b0, 8);
		op(1'b0, TOP, 16'h0, 1'b0, 8);
		op(1'b0, 21'd5, 16'h0, 1'b0, 8);
		op(1'b0, TOP, 16'h0001, 1'b1, 8);
		op(1'b0, TOP, 16'h1111, 1'b1, 8);
		`CHK(busConfig, 16'h9D0F)
		op(1'b1, {3'h2, 2'h0, 16'h1D1F}, 16'h0, 1'b1, 8);
		seen.delete();
		sawWait = 1'b0;
		op(1'b0, 21'd126, 16'h0, 1'b0, 14);
		for (i = 0; i < 3; i++)
			`CHK(seen[i], 21'(126 + i))
		`CHK(sawWait, 1'b1)
		rst;
		`CHK(busConfig, 16'h9D1F)
		op(1'b1, {3'h2, 2'h0, 16'h1D11}, 16'h0, 1'b1, 8);
		for (j = 0; j < 2; j++) begin
			seen.delete();
			op(1'b0, 21'd6, 16'h0, j[0], 12);
			for (i = 0; i < 4; i++)
				`CHK(seen[i], 21'(4 + (2 + i) % 4))
		end
		test_done;
	end
endmodule // tb_psram_config_register_access
bind pcr_register_access pcr_asserts chk_u (.clk(clk), .rst_n(rst_n),
	.configSelect(configSelect), .writeEnableN(writeEnableN),
	.outputEnableN(outputEnableN), .dqOe(dqOe), .arrayRead(arrayRead),
	.arrayWrite(arrayWrite), .arrayAddr(arrayAddr), .busConfig(busConfig),
	.refreshConfig(refreshConfig));
